// file: core/clk_switch_ctl.sv
// Processor-side controller running clock switch sequences over the register link
`timescale 1ns/100ps
module clk_switch_ctl
   import clk_switch_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   clk_switch_if.ctl bus,
   input wire logic [1:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] cmd_rdata
);
   typedef struct packed {
      act_type act;
      logic [7:0] set;
      logic [7:0] clr;
   } step_type;

   typedef struct packed {
      ctl_state_type st;
      logic [2:0] op;
      logic [2:0] step;
      logic [7:0] shadow;
      logic [6:0] code;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic busy;
      logic done;
      logic [7:0] rdata;
   } ctl_reg_type;

   ctl_reg_type q;
   ctl_reg_type d;
   step_type s;

   function automatic step_type prog(input logic [2:0] op, input logic [2:0] step);
      step_type r;
      r = '{act: ACT_END, set: 8'h00, clr: 8'h00};
      case ({op, step})
         // Combined start: quick PLL-on first, then core select, which the device drops while quick mode is on
         {OP_QUICK_START, 3'd0}: r.act = ACT_FETCH;
         {OP_QUICK_START, 3'd1}: r = '{ACT_WRCTRL, 8'h40, 8'h20};
         {OP_QUICK_START, 3'd2}: r = '{ACT_WRCTRL, 8'h01, 8'h00};
         // Combined stop: drop select, wait for it, then quick sleep
         {OP_SHUTDOWN, 3'd0}: r.act = ACT_FETCH;
         {OP_SHUTDOWN, 3'd1}: r = '{ACT_WRCTRL, 8'h00, 8'h01};
         {OP_SHUTDOWN, 3'd2}: r.act = ACT_POLL_SEL;
         {OP_SHUTDOWN, 3'd3}: r = '{ACT_WRCTRL, 8'h20, 8'h00};
         // Normal start: PLL enabled and locked before any select
         {OP_NORMAL_START, 3'd0}: r.act = ACT_WRCFG;
         {OP_NORMAL_START, 3'd1}: r.act = ACT_POLL_LOCK;
         {OP_NORMAL_START, 3'd2}: r.act = ACT_FETCH;
         {OP_NORMAL_START, 3'd3}: r = '{ACT_WRCTRL, 8'h81, 8'h00};
         {OP_DEEP_SLEEP, 3'd0}: r.act = ACT_FETCH;
         {OP_DEEP_SLEEP, 3'd1}: r = '{ACT_WRCTRL, 8'h00, 8'h01};
         {OP_DEEP_SLEEP, 3'd2}: r.act = ACT_POLL_SEL;
         {OP_DEEP_SLEEP, 3'd3}: r = '{ACT_WRCTRL, 8'h04, 8'h02};
         default: r.act = ACT_END;
      endcase
      return r;
   endfunction : prog

   assign s = prog(q.op, q.step);

   always_comb
   begin
      d = q;
      d.wr = 1'b0;
      d.rd = 1'b0;
      d.rdata = 8'h00;
      case (q.st)
         CS_IDLE:
            if (cmd_wr && cmd_addr == C_CMD_ADDR && cmd_wdata[2:0] >= OP_QUICK_START
                && cmd_wdata[2:0] <= OP_DEEP_SLEEP)
            begin
               d.op = cmd_wdata[2:0];
               d.step = 3'd0;
               d.busy = 1'b1;
               d.st = CS_EXEC;
            end
         CS_EXEC:
            case (s.act)
               ACT_FETCH, ACT_POLL_SEL:
               begin
                  d.addr = CTRL_ADDR;
                  d.rd = 1'b1;
                  d.st = CS_CAPT;
               end
               ACT_POLL_LOCK:
               begin
                  d.addr = LOCK_ADDR;
                  d.rd = 1'b1;
                  d.st = CS_CAPT;
               end
               ACT_WRCTRL:
               begin
                  d.shadow = (q.shadow | s.set) & ~s.clr;
                  d.addr = CTRL_ADDR;
                  d.wdata = (q.shadow | s.set) & ~s.clr;
                  d.wr = 1'b1;
                  d.step = q.step + 3'd1;
               end
               ACT_WRCFG:
               begin
                  d.addr = CFG_ADDR;
                  d.wdata = {1'b1, q.code};
                  d.wr = 1'b1;
                  d.step = q.step + 3'd1;
               end
               default:
               begin
                  d.busy = 1'b0;
                  d.done = 1'b1;
                  d.st = CS_IDLE;
               end
            endcase
         CS_CAPT:
         begin
            // Read data stand only in the cycle after the strobe, so let it pass first
            if (!q.rd)
            begin
               d.st = CS_EXEC;
               if (s.act == ACT_FETCH)
                  d.shadow = bus.sfr_rdata & ~8'h60;
               if (s.act == ACT_FETCH
                   || (s.act == ACT_POLL_LOCK && bus.sfr_rdata[B_LOCKED])
                   || (s.act == ACT_POLL_SEL && !bus.sfr_rdata[B_CORE_SEL]))
                  d.step = q.step + 3'd1;
            end
         end
         default: d.st = CS_IDLE;
      endcase
      if (cmd_wr && cmd_addr == C_FREQ_ADDR)
         d.code = cmd_wdata[6:0];
      if (cmd_rd)
      begin
         case (cmd_addr)
            C_STATUS_ADDR:
            begin
               d.rdata = {6'h00, q.done, q.busy};
               // Completion in the same cycle wins over the clear on read
               d.done = (q.st == CS_EXEC && s.act == ACT_END);
            end
            C_FREQ_ADDR: d.rdata = {1'b0, q.code};
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q.st <= CS_IDLE;
         q.op <= 3'h0;
         q.step <= 3'h0;
         q.shadow <= CTRL_RESET;
         q.code <= QUICK_FREQ_CODE;
         q.addr <= 16'h0000;
         q.wdata <= 8'h00;
         q.wr <= 1'b0;
         q.rd <= 1'b0;
         q.busy <= 1'b0;
         q.done <= 1'b0;
         q.rdata <= 8'h00;
      end
      else
      begin
         q <= d;
      end
   end

   assign bus.sfr_addr = q.addr;
   assign bus.sfr_wdata = q.wdata;
   assign bus.sfr_wr = q.wr;
   assign bus.sfr_rd = q.rd;
   assign cmd_rdata = q.rdata;
endmodule : clk_switch_ctl

// file: core/clk_switch_dev.sv
// Core and metering clock switchover device with quick and normal methods
`timescale 1ns/100ps
module clk_switch_dev
   import clk_switch_pkg::*;
#(
   parameter int CFG_W = 8
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   clk_switch_if.dev bus,
   input wire logic osc_tick,
   input wire logic pll_lock_in,
   input wire logic power_up_flag,
   input wire logic wake_event,
   output logic pll_enable,
   output logic [6:0] pll_freq_code,
   output logic core_clk_on_pll,
   output logic meter_clk_on_pll,
   output logic core_clk_run,
   output logic watchdog_clk_run,
   output logic meter_clk_run,
   output logic sleep_state,
   output logic deep_sleep_state,
   output logic temp_state
);
   if (CFG_W != DATA_W)
   begin : g_chk
      $error("CFG_W must equal the register width");
   end

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cfg;
      logic core_pll;
      logic meter_pll;
      logic core_back;
      logic meter_back;
      pwr_type pwr;
      logic temp;
      logic [7:0] rdata;
   } dev_state_type;

   dev_state_type q;
   dev_state_type d;

   function automatic pwr_type sleep_decode(input logic [1:0] req);
      pwr_type r;
      r = PWR_RUN;
      case (req)
         SLP_SLEEP_A, SLP_SLEEP_B: r = PWR_SLEEP;
         SLP_DEEP: r = PWR_DEEP;
         default: r = PWR_RUN;
      endcase
      return r;
   endfunction : sleep_decode

   logic quick_on;
   logic wr_ctrl;
   logic wr_cfg;
   logic [7:0] w;

   assign quick_on = ~q.ctrl[B_QSLEEP] & q.ctrl[B_QPLL];
   assign wr_ctrl = bus.sfr_wr & (bus.sfr_addr == CTRL_ADDR);
   assign wr_cfg = bus.sfr_wr & (bus.sfr_addr == CFG_ADDR);
   assign w = bus.sfr_wdata;

   always_comb
   begin
      d = q;
      d.rdata = 8'h00;
      // Source follows the select bits on the next crystal tick
      if (osc_tick)
      begin
         d.core_pll = q.ctrl[B_CORE_SEL];
         d.meter_pll = q.ctrl[B_METER_SEL];
         d.core_back = 1'b0;
         d.meter_back = 1'b0;
      end
      if (wr_ctrl)
      begin
         if (!quick_on)
         begin
            d.ctrl[B_CORE_SEL] = w[B_CORE_SEL];
            if (q.ctrl[B_CORE_SEL] && !w[B_CORE_SEL])
               d.core_back = 1'b1;
         end
         d.ctrl[B_METER_SEL] = w[B_METER_SEL];
         if (q.ctrl[B_METER_SEL] && !w[B_METER_SEL])
            d.meter_back = 1'b1;
         d.ctrl[B_QPLL] = w[B_QPLL];
         d.ctrl[B_QSLEEP] = w[B_QSLEEP];
         d.ctrl[B_METER_GATE] = w[B_METER_GATE];
         d.ctrl[B_LCD_GATE] = w[B_LCD_GATE];
         d.ctrl[B_SLEEP_HI:B_SLEEP_LO] = w[B_SLEEP_HI:B_SLEEP_LO];
         if (w[B_QSLEEP] && !power_up_flag)
            d.pwr = PWR_QSTOP;
         else if (!core_clk_on_pll && !q.core_back && !power_up_flag
                  && sleep_decode(w[B_SLEEP_HI:B_SLEEP_LO]) != PWR_RUN)
            d.pwr = sleep_decode(w[B_SLEEP_HI:B_SLEEP_LO]);
      end
      // Analog writes dropped while a switch back is pending
      if (wr_cfg && !q.core_back && !q.meter_back && !quick_on)
         d.cfg = w;
      // Quick stop: core to crystal, PLL off, then halt next cycle
      if (q.pwr == PWR_QSTOP)
      begin
         d.ctrl[B_CORE_SEL] = 1'b0;
         d.core_pll = 1'b0;
         d.core_back = 1'b0;
         d.cfg[B_CFG_PLL_EN] = 1'b0;
         d.pwr = PWR_SLEEP;
      end
      if (core_clk_on_pll)
         d.temp = 1'b0;
      // Wakeup clears request bits and restarts in the temporary state
      if (wake_event)
      begin
         d.ctrl[B_QPLL] = 1'b0;
         d.ctrl[B_QSLEEP] = 1'b0;
         d.ctrl[B_SLEEP_HI:B_SLEEP_LO] = 2'h0;
         d.pwr = PWR_RUN;
         d.temp = 1'b1;
      end
      if (bus.sfr_rd)
      begin
         case (bus.sfr_addr)
            CTRL_ADDR:
            begin
               d.rdata = q.ctrl;
               d.rdata[B_CORE_SEL] = q.ctrl[B_CORE_SEL] | q.core_back;
               d.rdata[B_METER_SEL] = q.ctrl[B_METER_SEL] | q.meter_back;
            end
            STATE_ADDR: d.rdata[B_PWR_UP] = power_up_flag;
            LOCK_ADDR: d.rdata[B_LOCKED] = pll_lock_in;
            CFG_ADDR: d.rdata = q.cfg;
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q.ctrl <= CTRL_RESET;
         q.cfg <= CFG_RESET;
         q.core_pll <= 1'b0;
         q.meter_pll <= 1'b0;
         q.core_back <= 1'b0;
         q.meter_back <= 1'b0;
         q.pwr <= PWR_RUN;
         q.temp <= 1'b1;
         q.rdata <= 8'h00;
      end
      else
      begin
         q <= d;
      end
   end

   // Quick mode overrides the PLL; a lost PLL falls back to crystal rate
   // in the analog block while the selects still read one
   assign pll_enable = q.cfg[B_CFG_PLL_EN] | quick_on;
   assign pll_freq_code = quick_on ? QUICK_FREQ_CODE : q.cfg[6:0];
   assign core_clk_on_pll = q.core_pll | quick_on;
   assign meter_clk_on_pll = q.meter_pll;
   assign core_clk_run = (q.pwr == PWR_RUN) || (q.pwr == PWR_QSTOP);
   assign watchdog_clk_run = core_clk_run;
   assign meter_clk_run = ~(q.ctrl[B_METER_GATE] & ~q.meter_pll & ~q.meter_back);
   assign sleep_state = (q.pwr == PWR_SLEEP);
   assign deep_sleep_state = (q.pwr == PWR_DEEP);
   assign temp_state = q.temp;
   assign bus.sfr_rdata = q.rdata;
endmodule : clk_switch_dev

// file: inc/clk_switch_if.sv
// Special function register link between the processor-side controller and the device
`timescale 1ns/100ps
interface clk_switch_if;
   import clk_switch_pkg::*;
   logic [ADDR_W-1:0] sfr_addr;
   logic [DATA_W-1:0] sfr_wdata;
   logic sfr_wr;
   logic sfr_rd;
   logic [DATA_W-1:0] sfr_rdata;
   modport dev (input sfr_addr, input sfr_wdata, input sfr_wr, input sfr_rd,
                output sfr_rdata);
   modport ctl (output sfr_addr, output sfr_wdata, output sfr_wr, output sfr_rd,
                input sfr_rdata);
endinterface : clk_switch_if

// file: inc/clk_switch_pkg.sv
// Shared constants and types for the clock switchover device and its controller
package clk_switch_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] CTRL_ADDR = 16'h0080;
   localparam logic [15:0] STATE_ADDR = 16'h00A1;
   localparam logic [15:0] LOCK_ADDR = 16'h00A3;
   localparam logic [15:0] CFG_ADDR = 16'h2867;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int B_CORE_SEL = 0;
   localparam int B_SLEEP_LO = 1;
   localparam int B_SLEEP_HI = 2;
   localparam int B_LCD_GATE = 3;
   localparam int B_METER_GATE = 4;
   localparam int B_QSLEEP = 5;
   localparam int B_QPLL = 6;
   localparam int B_METER_SEL = 7;
   localparam int B_PWR_UP = 0;
   localparam int B_LOCKED = 0;
   localparam int B_CFG_PLL_EN = 7;
   // Frequency code giving the fixed 3.2768 MHz quick-mode PLL rate
   localparam logic [6:0] QUICK_FREQ_CODE = 7'h01;
   localparam logic [1:0] SLP_SLEEP_A = 2'h3;
   localparam logic [1:0] SLP_SLEEP_B = 2'h1;
   localparam logic [1:0] SLP_DEEP = 2'h2;
   localparam int CLK_HZ = 50_000_000;
   localparam int WAKE_MIN_US = 800;
   localparam int WAKE_MAX_US = 900;
   localparam int STOP_MAX_NS = 30000;
   localparam int WAKE_MIN_CYC = (WAKE_MIN_US * (CLK_HZ / 1_000_000));
   localparam int WAKE_MAX_CYC = (WAKE_MAX_US * (CLK_HZ / 1_000_000));
   localparam int STOP_MAX_CYC = (STOP_MAX_NS / (1_000_000_000 / CLK_HZ));
   // Controller's own command port
   localparam logic [1:0] C_CMD_ADDR = 2'h0;
   localparam logic [1:0] C_STATUS_ADDR = 2'h1;
   localparam logic [1:0] C_FREQ_ADDR = 2'h2;
   localparam logic [2:0] OP_QUICK_START = 3'h1;
   localparam logic [2:0] OP_SHUTDOWN = 3'h2;
   localparam logic [2:0] OP_NORMAL_START = 3'h3;
   localparam logic [2:0] OP_DEEP_SLEEP = 3'h4;
   typedef enum logic [2:0] {ACT_FETCH, ACT_WRCTRL, ACT_WRCFG, ACT_POLL_LOCK, ACT_POLL_SEL,
                             ACT_END} act_type;
   typedef enum {PWR_RUN, PWR_QSTOP, PWR_SLEEP, PWR_DEEP} pwr_type;
   typedef enum {CS_IDLE, CS_EXEC, CS_CAPT} ctl_state_type;
endpackage : clk_switch_pkg

// file: tb/clk_switch_props.sv
// Checks on the register link and clock outputs of the switchover pair
`timescale 1ns/100ps
module clk_switch_props
   import clk_switch_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] sfr_addr,
   input wire logic [DATA_W-1:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [DATA_W-1:0] sfr_rdata,
   input wire logic power_up_flag,
   input wire logic wake_event,
   input wire logic pll_enable,
   input wire logic [6:0] pll_freq_code,
   input wire logic core_clk_on_pll,
   input wire logic meter_clk_on_pll,
   input wire logic core_clk_run,
   input wire logic watchdog_clk_run,
   input wire logic sleep_state,
   input wire logic deep_sleep_state,
   input wire logic temp_state
);
   logic ctrl_wr;
   logic [1:0] qbits_q;
   assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
   // Quick bits are not visible at the outputs, so shadow them
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         qbits_q <= 2'h0;
      else if (wake_event)
         qbits_q <= 2'h0;
      else if (ctrl_wr)
         qbits_q <= sfr_wdata[6:5];
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence quick_stop_req;
      ctrl_wr && sfr_wdata[B_QSLEEP] && !power_up_flag && !wake_event;
   endsequence
   sequence core_halted;
      sleep_state && !core_clk_run && !watchdog_clk_run && !pll_enable && !core_clk_on_pll;
   endsequence
   sequence sleep_req;
      ctrl_wr && sfr_wdata[2:1] != 2'h0 && sfr_wdata[6:5] == 2'h0 && !sfr_wdata[0]
         && !core_clk_on_pll && !power_up_flag && !sleep_state && !deep_sleep_state
         && !wake_event;
   endsequence
   AST_RESET_DEFAULTS: assert property (
      $rose(nrst) |-> !pll_enable && !core_clk_on_pll && !meter_clk_on_pll && core_clk_run)
      else $error("clock outputs not at defaults after reset");
   AST_RDATA_IDLE: assert property (
      !$past(sfr_rd) |-> sfr_rdata == 8'h00)
      else $error("read data outside its slot");
   AST_POLL_SEL: assert property (
      sfr_rd && sfr_addr == CTRL_ADDR && core_clk_on_pll && qbits_q != 2'h2
      |=> sfr_rdata[B_CORE_SEL])
      else $error("core select read zero before switch back");
   AST_CORE_BACK: assert property (
      ctrl_wr && !sfr_wdata[0] && sfr_wdata[6:5] == 2'h0 && core_clk_on_pll
      && qbits_q != 2'h2 && !wake_event |-> ##[1:9] !core_clk_on_pll)
      else $error("core clock slow to return to crystal");
   AST_SLEEP_DECODE: assert property (
      sleep_req |=> !core_clk_run && !watchdog_clk_run
      && deep_sleep_state == ($past(sfr_wdata[2:1]) == SLP_DEEP)
      && sleep_state == ($past(sfr_wdata[2:1]) != SLP_DEEP))
      else $error("sleep request decoded wrongly");
   AST_QUICK_ON: assert property (
      ctrl_wr && sfr_wdata[6:5] == 2'h2 && !wake_event
      |=> core_clk_on_pll && pll_enable && pll_freq_code == QUICK_FREQ_CODE)
      else $error("quick start did not move core clock");
   AST_QUICK_STOP: assert property (
      quick_stop_req |-> ##2 core_halted)
      else $error("quick stop did not halt core clock");
   AST_QUICK_HOLD: assert property (
      sfr_wr && sfr_addr == CFG_ADDR && qbits_q == 2'h2
      |=> pll_freq_code == QUICK_FREQ_CODE && pll_enable)
      else $error("frequency changed during quick mode");
   AST_WAKE: assert property (
      wake_event |=> temp_state && core_clk_run && watchdog_clk_run
      && !sleep_state && !deep_sleep_state)
      else $error("wakeup did not restore run state");
endmodule : clk_switch_props

// file: tb/core_meter_clock_switch_test.sv
// Self-checking bench for the clock switch controller and device pair
`timescale 1ns/100ps
module core_meter_clock_switch_test;
   import clk_switch_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic osc_tick = 1'b0;
   logic pll_lock_in = 1'b0;
   logic power_up_flag = 1'b0;
   logic wake_event = 1'b0;
   logic [1:0] cmd_addr = 2'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [7:0] cmd_rdata;
   logic pll_enable, core_clk_on_pll, meter_clk_on_pll, core_clk_run, watchdog_clk_run;
   logic sleep_state, deep_sleep_state, temp_state, meter_clk_run;
   logic [6:0] pll_freq_code;
   logic [6:0] code_keep = 7'h00;
   logic [15:0] outs, mon_m;
   logic [15:0] exp_v[$];
   logic [15:0] exp_m[$];
   logic snap = 1'b0;
   logic [31:0] rnd = 32'h00011C5F;
   logic [2:0] tick_cnt = 3'h0;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   clk_switch_if u_clk_switch_if ();
   clk_switch_dev u_clk_switch_dev (.sys_clk(sys_clk), .nrst(nrst), .bus(u_clk_switch_if.dev),
      .osc_tick(osc_tick), .pll_lock_in(pll_lock_in), .power_up_flag(power_up_flag),
      .wake_event(wake_event), .pll_enable(pll_enable), .pll_freq_code(pll_freq_code),
      .core_clk_on_pll(core_clk_on_pll), .meter_clk_on_pll(meter_clk_on_pll),
      .core_clk_run(core_clk_run), .watchdog_clk_run(watchdog_clk_run),
      .meter_clk_run(meter_clk_run),
      .sleep_state(sleep_state), .deep_sleep_state(deep_sleep_state), .temp_state(temp_state));
   clk_switch_ctl u_clk_switch_ctl (.sys_clk(sys_clk), .nrst(nrst), .bus(u_clk_switch_if.ctl),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_rdata(cmd_rdata));
   clk_switch_props u_clk_switch_props (.sys_clk(sys_clk), .nrst(nrst),
      .sfr_addr(u_clk_switch_if.sfr_addr), .sfr_wdata(u_clk_switch_if.sfr_wdata),
      .sfr_wr(u_clk_switch_if.sfr_wr), .sfr_rd(u_clk_switch_if.sfr_rd),
      .sfr_rdata(u_clk_switch_if.sfr_rdata), .power_up_flag(power_up_flag),
      .wake_event(wake_event), .pll_enable(pll_enable), .pll_freq_code(pll_freq_code),
      .core_clk_on_pll(core_clk_on_pll), .meter_clk_on_pll(meter_clk_on_pll),
      .core_clk_run(core_clk_run), .watchdog_clk_run(watchdog_clk_run),
      .sleep_state(sleep_state), .deep_sleep_state(deep_sleep_state), .temp_state(temp_state));
   assign outs = {meter_clk_run, pll_freq_code, pll_enable, core_clk_on_pll, meter_clk_on_pll,
      core_clk_run,
      watchdog_clk_run, sleep_state, deep_sleep_state, temp_state};
   always #10 sys_clk = ~sys_clk;
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // Crystal tick every 8 cycles; lock trails the enable by one cycle
   always @(posedge sys_clk)
   begin
      tick_cnt <= tick_cnt + 3'h1;
      osc_tick <= (tick_cnt == 3'h7);
      pll_lock_in <= pll_enable;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         test_done();
      end
   end
   always @(posedge sys_clk)
   begin
      if (snap)
      begin
         mon_m = exp_m.pop_front();
         check("clock outputs", outs & mon_m, exp_v.pop_front() & mon_m);
      end
   end
   task automatic cmd_access(input logic [1:0] a, input logic [7:0] d, input logic wr);
      @(posedge sys_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= wr;
      cmd_rd <= !wr;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      #1;
   endtask : cmd_access
   // Polls status until done; a stuck sequence counts as a mismatch
   task automatic run_op(input logic [2:0] op);
      int n;
      n = 0;
      cmd_access(C_CMD_ADDR, {5'h00, op}, 1'b1);
      cmd_access(C_STATUS_ADDR, 8'h00, 1'b0);
      while (cmd_rdata[1] !== 1'b1 && n < 300)
      begin
         cmd_access(C_STATUS_ADDR, 8'h00, 1'b0);
         n = n + 1;
      end
      if (n == 300)
         fail_count = fail_count + 1;
   endtask : run_op
   task automatic expect_out(input logic [15:0] v, input logic [15:0] m);
      exp_v.push_back(v);
      exp_m.push_back(m);
      // Source changes wait for a crystal tick, which comes every eight cycles
      repeat (8) @(posedge sys_clk);
      @(posedge sys_clk);
      snap <= 1'b1;
      @(posedge sys_clk);
      snap <= 1'b0;
   endtask : expect_out
   task automatic wake();
      @(posedge sys_clk);
      wake_event <= 1'b1;
      @(posedge sys_clk);
      wake_event <= 1'b0;
      @(posedge sys_clk);
   endtask : wake
   initial
   begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      expect_out(16'h8019, 16'h80FF);
      for (int i = 0; i < 2; i++)
      begin
         rnd = xorshift(rnd);
         cmd_access(C_FREQ_ADDR, {1'b0, rnd[6:0]}, 1'b1);
         run_op(OP_NORMAL_START);
         expect_out({1'b1, rnd[6:0], 8'hF8}, 16'hFFFE);
      end
      code_keep = rnd[6:0];
      run_op(OP_DEEP_SLEEP);
      expect_out(16'h00A2, 16'h00FE);
      wake();
      expect_out(16'h0019, 16'h001F);
      run_op(OP_QUICK_START);
      expect_out(16'h01D8, 16'h7FDE);
      rnd = xorshift(rnd);
      cmd_access(C_FREQ_ADDR, {1'b0, rnd[6:0]}, 1'b1);
      run_op(OP_NORMAL_START);
      // New code dropped in quick mode; the core select write is dropped too, so crystal
      expect_out({1'b1, code_keep, 8'hB8}, 16'hFFFE);
      run_op(OP_SHUTDOWN);
      expect_out(16'h0004, 16'h00DC);
      wake();
      power_up_flag <= 1'b1;
      run_op(OP_SHUTDOWN);
      cmd_access(2'h3, 8'hFF, 1'b1);
      expect_out(16'h0018, 16'h001C);
      power_up_flag <= 1'b0;
      repeat (2) @(posedge sys_clk);
      test_done();
   end
endmodule : core_meter_clock_switch_test
